// ---- verilog/pmrc_ctrl.sv ----
// Purpose: System power mode combiner, reset collector and clock allocation
// Assumes: Single 100 MHz clock, synchronous inputs, Wishbone classic slave
// Notes: Oscillators and PLLs are outside; this block drives their enables
`timescale 1ns/1ps

module pmrc_ctrl
    import pmrc_pkg::*;
#(
    parameter int N_GATES = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire pmrc_cpu_req_t app_req,
    input wire pmrc_cpu_req_t mcu_req,
    input wire logic wakeup_pending,
    input wire pmrc_rst_src_t rst_src,
    input wire logic [1:0] brownout_level_sel,
    input wire logic [2:0] vdd_below_level,
    input wire logic external_fast_osc_fail,
    output pmrc_cpu_t app_state,
    output pmrc_cpu_t mcu_state,
    output pmrc_sys_t sys_mode,
    output logic bus_clk_stall,
    output logic osc_enable,
    output logic low_power_regulator,
    output logic core_domain_power,
    output logic app_reset,
    output logic sys_reset,
    output logic [2:0] sys_clk_src,
    output logic [2:0] kernel_clk_src,
    output logic [3:0] pll_enable,
    output logic [N_GATES-1:0] periph_clk_en,
    output logic cpu_clk_en,
    output logic bus_clk_en
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [8:0] ctrl_reg;
    logic [2:0] sys_src_reg;
    logic [2:0] ker_src_reg;
    logic [3:0] pll_reg;
    logic [N_GATES-1:0] gate_reg;
    logic [3:0] cpu_div_reg;
    logic [3:0] bus_div_reg;
    logic [PMRC_NRF-1:0] flags_reg;
    logic por_seen_reg;
    logic [3:0] cpu_cnt_reg;
    logic [3:0] bus_cnt_reg;
    logic [3:0] rst_cnt_reg;
    logic [PMRC_NRF-1:0] cause_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire hit_ctrl = wb_adr_i == PMRC_OFF_CTRL;
    wire hit_stat = wb_adr_i == PMRC_OFF_STAT;
    wire hit_clk = wb_adr_i == PMRC_OFF_CLKSEL;
    wire hit_gate = wb_adr_i == PMRC_OFF_GATE;
    wire hit_rstf = wb_adr_i == PMRC_OFF_RSTF;
    wire hit_div = wb_adr_i == PMRC_OFF_DIV;
    wire hit_any = hit_ctrl | hit_stat | hit_clk | hit_gate | hit_rstf | hit_div;
    wire wr = bus_req & wb_we_i & hit_any;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Reset sources
    // ----------------------------------------------------------------
    // Brownout compares against the option-selected threshold only
    wire bor_hit = rst_src.bor | (brownout_level_sel != 2'b11 &&
                   vdd_below_level[brownout_level_sel]);
    wire css_hit = ctrl_reg[PMRC_CTRL_CSS_EN] & external_fast_osc_fail;
    wire app_src = rst_src.pad | rst_src.por | bor_hit | rst_src.wdg1 | rst_src.wdg2 |
                   ctrl_reg[PMRC_CTRL_SWRST_MCU] | ctrl_reg[PMRC_CTRL_SWRST_APP] |
                   css_hit;
    wire stby_exit = sys_mode == PMRC_S_STBY && wakeup_pending;
    wire sys_src = app_src | rst_src.core_por | stby_exit;
    wire [PMRC_NRF-1:0] cause_now = {stby_exit, rst_src.core_por, css_hit,
        ctrl_reg[PMRC_CTRL_SWRST_APP], ctrl_reg[PMRC_CTRL_SWRST_MCU], rst_src.wdg2,
        rst_src.wdg1, bor_hit, rst_src.por, rst_src.pad};
    // Power-on reset replaces all flags with the current causes at once, either the supervisor or the first cycle after rst_n
    wire por_clear = rst_src.por | ~por_seen_reg;

    // ----------------------------------------------------------------
    // Per-CPU and system mode
    // ----------------------------------------------------------------
    function automatic pmrc_cpu_t cpu_next(input pmrc_cpu_t cur, input pmrc_cpu_req_t q,
                                           input logic wake, input logic stby_ok);
        logic ask;
        ask = q.wait_for_interrupt_instr | q.wait_for_event_instr | (q.handler_ret & q.sleep_after_handler_return);
        unique case (cur)
            PMRC_C_RUN: begin
                if (ask && q.stby_req && stby_ok && !wake) begin
                    return PMRC_C_STBY;
                end else if (ask && q.deep && !wake) begin
                    return PMRC_C_STOP;
                end else if (ask) begin
                    return PMRC_C_SLEEP;
                end
                return PMRC_C_RUN;
            end
            PMRC_C_SLEEP: return (wake | ~ask) ? PMRC_C_RUN : PMRC_C_SLEEP;
            PMRC_C_STOP: return wake ? PMRC_C_RUN : PMRC_C_STOP;
            // Standby leaves only through a system reset, such as the one that the wakeup raises
            PMRC_C_STBY: return PMRC_C_STBY;
        endcase
    endfunction

    wire pmrc_cpu_t app_next = cpu_next(app_state, app_req, wakeup_pending, 1'b1);
    wire pmrc_cpu_t mcu_next = cpu_next(mcu_state, mcu_req, wakeup_pending, 1'b0);
    wire app_low = app_state == PMRC_C_STOP || app_state == PMRC_C_STBY;
    wire mcu_low = mcu_state == PMRC_C_STOP;
    wire stop_ok = app_low & mcu_low & ~wakeup_pending;
    wire stby_ok = stop_ok && (app_state == PMRC_C_STBY || (app_state == PMRC_C_STOP &&
                   ctrl_reg[PMRC_CTRL_APP_POWER_DOWN_DEEP_SLEEP_SEL] && ctrl_reg[PMRC_CTRL_APP_CPU_STANDBY_DISABLE])) &&
                   ctrl_reg[PMRC_CTRL_MCU_POWER_DOWN_DEEP_SLEEP_SEL];
    wire pmrc_sys_t sys_next = stby_ok ? PMRC_S_STBY :
                               stop_ok ? PMRC_S_STOP : PMRC_S_RUN;

    // ----------------------------------------------------------------
    // Clock dividers
    // ----------------------------------------------------------------
    wire cpu_tick = cpu_cnt_reg >= cpu_div_reg;
    wire bus_tick = bus_cnt_reg >= bus_div_reg;

    // ----------------------------------------------------------------
    // Register write and state update
    // ----------------------------------------------------------------
    wire [31:0] ctrl_wr = merge({23'h0, ctrl_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] clk_wr = merge({20'h0, pll_reg, 1'b0, ker_src_reg, 1'b0, sys_src_reg},
                               wb_dat_i, wb_sel_i);
    wire [31:0] div_wr = merge({24'h0, bus_div_reg, cpu_div_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] gate_wr = merge(32'(gate_reg), wb_dat_i, wb_sel_i);

    always_ff @(posedge clock) begin
        if (!rst_n || sys_reset) begin
            ctrl_reg <= PMRC_CTRL_RESET;
            sys_src_reg <= PMRC_SRC_FAST_INT;
            gate_reg <= N_GATES'(PMRC_GATE_RESET);
            cpu_div_reg <= PMRC_DIV_RESET[3:0];
            bus_div_reg <= PMRC_DIV_RESET[7:4];
            app_state <= PMRC_C_RUN;
            mcu_state <= PMRC_C_RUN;
            sys_mode <= PMRC_S_RUN;
        end else begin
            if (wr && hit_ctrl) ctrl_reg <= ctrl_wr[8:0];
            if (wr && hit_clk) sys_src_reg <= clk_wr[2:0];
            if (wr && hit_gate) gate_reg <= gate_wr[N_GATES-1:0];
            if (wr && hit_div) begin
                cpu_div_reg <= div_wr[3:0];
                bus_div_reg <= div_wr[7:4];
            end
            app_state <= app_next;
            mcu_state <= mcu_next;
            sys_mode <= sys_next;
        end
    end

    // Kernel source and PLLs sit in the clock part that system reset spares
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ker_src_reg <= PMRC_SRC_FAST_INT;
            pll_reg <= 4'h0;
            flags_reg <= '0;
            por_seen_reg <= 1'b0;
            rst_cnt_reg <= 4'h0;
            cause_reg <= '0;
        end else begin
            if (wr && hit_clk) begin
                ker_src_reg <= clk_wr[6:4];
                pll_reg <= clk_wr[11:8];
            end
            por_seen_reg <= 1'b1;
            cause_reg <= cause_now;
            // New causes win over the software clear
            if (por_clear) flags_reg <= cause_now;
            else if (wr && hit_rstf) flags_reg <= (flags_reg & ~wb_dat_i[PMRC_NRF-1:0]) |
                                                  cause_now;
            else flags_reg <= flags_reg | cause_now;
            rst_cnt_reg <= sys_src ? PMRC_RST_CYC : rst_cnt_reg - 4'(rst_cnt_reg != 4'h0);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cpu_cnt_reg <= 4'h0;
            bus_cnt_reg <= 4'h0;
        end else begin
            cpu_cnt_reg <= cpu_tick ? 4'h0 : cpu_cnt_reg + 4'h1;
            bus_cnt_reg <= bus_tick ? 4'h0 : bus_cnt_reg + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    wire stopped = sys_mode != PMRC_S_RUN;
    wire lp_sel = ctrl_reg[PMRC_CTRL_LP] | ctrl_reg[PMRC_CTRL_LPLV];
    wire [31:0] rd_mux = hit_ctrl ? {23'h0, ctrl_reg} :
        hit_stat ? {24'h0, sys_mode, mcu_state, app_state, 2'b00} :
        hit_clk ? {20'h0, pll_reg, 1'b0, ker_src_reg, 1'b0, sys_src_reg} :
        hit_gate ? 32'(gate_reg) :
        hit_rstf ? {22'h0, flags_reg} : {24'h0, bus_div_reg, cpu_div_reg};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            bus_clk_stall <= 1'b0;
            osc_enable <= 1'b1;
            low_power_regulator <= 1'b0;
            core_domain_power <= 1'b1;
            app_reset <= 1'b1;
            sys_reset <= 1'b1;
            sys_clk_src <= PMRC_SRC_FAST_INT;
            kernel_clk_src <= PMRC_SRC_FAST_INT;
            pll_enable <= 4'h0;
            periph_clk_en <= '0;
            cpu_clk_en <= 1'b0;
            bus_clk_en <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & hit_any;
            wb_err_o <= bus_req & ~hit_any;
            wb_dat_o <= (bus_req & hit_any & ~wb_we_i) ? rd_mux : 32'h00000000;
            bus_clk_stall <= stopped;
            osc_enable <= ~(stopped & ctrl_reg[PMRC_CTRL_OSC_OFF]);
            low_power_regulator <= sys_mode == PMRC_S_STOP && lp_sel;
            core_domain_power <= sys_mode != PMRC_S_STBY;
            app_reset <= app_src || cause_reg[PMRC_RF_SW_APP:PMRC_RF_PAD] != '0;
            sys_reset <= sys_src || rst_cnt_reg != 4'h0;
            sys_clk_src <= sys_src_reg;
            kernel_clk_src <= ker_src_reg;
            pll_enable <= stopped ? 4'h0 : pll_reg;
            periph_clk_en <= stopped ? '0 : gate_reg;
            cpu_clk_en <= cpu_tick & app_state == PMRC_C_RUN;
            bus_clk_en <= bus_tick & ~stopped;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_stby_needs_bits;
        @(posedge clock) disable iff (!rst_n)
        sys_mode == PMRC_S_STBY |-> $past(ctrl_reg[PMRC_CTRL_MCU_POWER_DOWN_DEEP_SLEEP_SEL]);
    endproperty
    a_stby_needs_bits: assert property (p_stby_needs_bits) else $error("standby w/o bit");
    property p_run_if_active;
        @(posedge clock) disable iff (!rst_n || sys_reset)
        mcu_state inside {PMRC_C_RUN, PMRC_C_SLEEP} |=> sys_mode == PMRC_S_RUN;
    endproperty
    a_run_if_active: assert property (p_run_if_active) else $error("left run");
    property p_stall;
        @(posedge clock) disable iff (!rst_n)
        sys_mode != PMRC_S_RUN |=> bus_clk_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall");
    property p_stby_power;
        @(posedge clock) disable iff (!rst_n)
        sys_mode == PMRC_S_STBY |=> !core_domain_power;
    endproperty
    a_stby_power: assert property (p_stby_power) else $error("core on");
    property p_lpreg;
        @(posedge clock) disable iff (!rst_n)
        low_power_regulator |-> $past(sys_mode) == PMRC_S_STOP;
    endproperty
    a_lpreg: assert property (p_lpreg) else $error("lp signal");
    property p_sysrst;
        @(posedge clock) disable iff (!rst_n)
        app_src |=> sys_reset [*2];
    endproperty
    a_sysrst: assert property (p_sysrst) else $error("no sys reset");
    property p_css;
        @(posedge clock) disable iff (!rst_n)
        css_hit |=> app_reset && flags_reg[PMRC_RF_CSS];
    endproperty
    a_css: assert property (p_css) else $error("css missed");
    property p_wake;
        @(posedge clock) disable iff (!rst_n || sys_reset)
        wakeup_pending && mcu_state == PMRC_C_STOP |=> mcu_state == PMRC_C_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_src_after_rst;
        @(posedge clock) disable iff (!rst_n)
        $fell(sys_reset) |-> sys_src_reg == PMRC_SRC_FAST_INT;
    endproperty
    a_src_after_rst: assert property (p_src_after_rst) else $error("clk src");
    c_stop: cover property (@(posedge clock) sys_mode == PMRC_S_STOP);
    c_stby: cover property (@(posedge clock) sys_mode == PMRC_S_STBY);
    c_wake: cover property (@(posedge clock) $fell(bus_clk_stall));
    c_rst: cover property (@(posedge clock) $rose(app_reset));

endmodule

// ---- verilog/pmrc_pkg.sv ----
// Purpose: Shared constants and types for the power mode and reset controller
// Assumes: Wishbone classic slave, 32-bit data, word-aligned registers
// Notes: Offsets are byte addresses
package pmrc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] PMRC_OFF_CTRL = 8'h00;
    localparam logic [7:0] PMRC_OFF_STAT = 8'h04;
    localparam logic [7:0] PMRC_OFF_CLKSEL = 8'h08;
    localparam logic [7:0] PMRC_OFF_GATE = 8'h0C;
    localparam logic [7:0] PMRC_OFF_RSTF = 8'h10;
    localparam logic [7:0] PMRC_OFF_DIV = 8'h14;

    // CTRL fields
    localparam int PMRC_CTRL_APP_POWER_DOWN_DEEP_SLEEP_SEL = 0;
    localparam int PMRC_CTRL_APP_CPU_STANDBY_DISABLE = 1;
    localparam int PMRC_CTRL_MCU_POWER_DOWN_DEEP_SLEEP_SEL = 2;
    localparam int PMRC_CTRL_LP = 3;
    localparam int PMRC_CTRL_LPLV = 4;
    localparam int PMRC_CTRL_OSC_OFF = 5;
    localparam int PMRC_CTRL_CSS_EN = 6;
    localparam int PMRC_CTRL_SWRST_APP = 7;
    localparam int PMRC_CTRL_SWRST_MCU = 8;
    localparam logic [8:0] PMRC_CTRL_RESET = 9'h000;

    // Clock select and divider fields
    localparam logic [2:0] PMRC_SRC_FAST_INT = 3'h0;
    localparam logic [2:0] PMRC_SRC_MID_INT = 3'h1;
    localparam logic [2:0] PMRC_SRC_SLOW_INT = 3'h2;
    localparam logic [2:0] PMRC_SRC_FAST_EXT = 3'h3;
    localparam logic [2:0] PMRC_SRC_SLOW_EXT = 3'h4;
    localparam logic [2:0] PMRC_SRC_PLL = 3'h5;
    localparam logic [7:0] PMRC_DIV_RESET = 8'h00;
    localparam logic [31:0] PMRC_GATE_RESET = 32'hFFFFFFFF;

    // Reset cause flag positions
    localparam int PMRC_RF_PAD = 0;
    localparam int PMRC_RF_POR = 1;
    localparam int PMRC_RF_BOR = 2;
    localparam int PMRC_RF_WDG1 = 3;
    localparam int PMRC_RF_WDG2 = 4;
    localparam int PMRC_RF_SW_MCU = 5;
    localparam int PMRC_RF_SW_APP = 6;
    localparam int PMRC_RF_CSS = 7;
    localparam int PMRC_RF_CORE = 8;
    localparam int PMRC_RF_STBY = 9;
    localparam int PMRC_NRF = 10;

    // System reset pulse length
    localparam int PMRC_RST_PULSE_NS = 100;
    localparam int PMRC_CLK_MHZ = 100;
    localparam logic [3:0] PMRC_RST_CYC = 4'((PMRC_RST_PULSE_NS * PMRC_CLK_MHZ) / 1000);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PMRC_C_RUN = 2'b00,
        PMRC_C_SLEEP = 2'b01,
        PMRC_C_STOP = 2'b10,
        PMRC_C_STBY = 2'b11
    } pmrc_cpu_t;

    typedef enum logic [1:0] {
        PMRC_S_RUN = 2'b00,
        PMRC_S_STOP = 2'b01,
        PMRC_S_STBY = 2'b10
    } pmrc_sys_t;

    typedef struct packed {
        logic pad;
        logic por;
        logic bor;
        logic wdg1;
        logic wdg2;
        logic core_por;
    } pmrc_rst_src_t;

    typedef struct packed {
        logic wait_for_interrupt_instr;
        logic wait_for_event_instr;
        logic handler_ret;
        logic sleep_after_handler_return;
        logic deep;
        logic stby_req;
    } pmrc_cpu_req_t;

endpackage

// ---- dv/pmrc_cpu_model.sv ----
// Purpose: Behavioural model of the two cores' low-power requests
// Assumes: Mode codes from the bench: 0 run, 1 sleep, 2 stop, 3 standby
// Notes: Requests are levels held while a core sits in its wait
`timescale 1ns/1ps
module pmrc_cpu_model
    import pmrc_pkg::*;
(
    input wire logic clock,
    input wire logic [1:0] app_mode,
    input wire logic [1:0] mcu_mode,
    output pmrc_cpu_req_t app_req,
    output pmrc_cpu_req_t mcu_req
);
    // ----------------------------------------------------------------
    // Request encoding
    // ----------------------------------------------------------------
    // The mcu uses the event wait and handler return so every entry route is exercised
    always_ff @(posedge clock) begin
        app_req <= '0;
        mcu_req <= '0;
        app_req.wait_for_interrupt_instr <= app_mode != 2'h0;
        app_req.deep <= app_mode[1];
        app_req.stby_req <= app_mode == 2'h3;
        mcu_req.handler_ret <= mcu_mode == 2'h1;
        mcu_req.sleep_after_handler_return <= mcu_mode == 2'h1;
        mcu_req.wait_for_event_instr <= mcu_mode[1];
        mcu_req.deep <= mcu_mode[1];
    end
endmodule

// ---- dv/pmrc_testbench.sv ----
// Purpose: Self-checking bench for the power mode and reset controller
// Assumes: Wishbone classic master tasks, core model on the request ports
// Notes: The ack and reset waits have no bound of their own; a watchdog cuts a hang short
`timescale 1ns/1ps
module testbench
    import pmrc_pkg::*;
;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o, wb_err_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, periph_clk_en;
    logic wakeup_pending = 1'h0, external_fast_osc_fail = 1'h0, er;
    pmrc_rst_src_t rst_src = '0;
    logic [1:0] brownout_level_sel = 2'h3, app_mode = 2'h0, mcu_mode = 2'h0;
    logic [2:0] vdd_below_level = 3'h0, sys_clk_src, kernel_clk_src;
    pmrc_cpu_req_t app_req, mcu_req;
    pmrc_cpu_t app_state, mcu_state;
    pmrc_sys_t sys_mode;
    logic bus_clk_stall, osc_enable, low_power_regulator, core_domain_power;
    logic app_reset, sys_reset, cpu_clk_en, bus_clk_en;
    logic [3:0] pll_enable;
    logic [5:0] srcv [5] = '{6'h20, 6'h08, 6'h04, 6'h02, 6'h01};
    int flg [5] = '{PMRC_RF_PAD, PMRC_RF_BOR, PMRC_RF_WDG1, PMRC_RF_WDG2, PMRC_RF_CORE};
    int fail_count = 0;
    int tests_run = 0;
    int cpu_pulses = 0;
    int bus_pulses = 0;

    always #5 clock = ~clock;

    pmrc_ctrl dut_u (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .app_req(app_req),
        .mcu_req(mcu_req), .wakeup_pending(wakeup_pending), .rst_src(rst_src),
        .brownout_level_sel(brownout_level_sel), .vdd_below_level(vdd_below_level),
        .external_fast_osc_fail(external_fast_osc_fail), .app_state(app_state),
        .mcu_state(mcu_state), .sys_mode(sys_mode), .bus_clk_stall(bus_clk_stall),
        .osc_enable(osc_enable), .low_power_regulator(low_power_regulator),
        .core_domain_power(core_domain_power), .app_reset(app_reset), .sys_reset(sys_reset),
        .sys_clk_src(sys_clk_src), .kernel_clk_src(kernel_clk_src), .pll_enable(pll_enable),
        .periph_clk_en(periph_clk_en), .cpu_clk_en(cpu_clk_en), .bus_clk_en(bus_clk_en));

    pmrc_cpu_model cpu_u (.clock(clock), .app_mode(app_mode), .mcu_mode(mcu_mode),
        .app_req(app_req), .mcu_req(mcu_req));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (fail_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Classic single cycle: request held until ack or err is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        @(posedge clock);
        while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1) begin
            @(posedge clock);
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask

    // A reset launched at this edge is not yet visible, so look two edges later
    task automatic wait_rst;
        repeat (2) @(posedge clock);
        while (sys_reset !== 1'h0) begin
            @(posedge clock);
        end
        repeat (2) @(posedge clock);
    endtask

    // Cause flags are sticky, so each check clears what it found
    task automatic flag_chk(input int b);
        wait_rst;
        wb(1'h0, PMRC_OFF_RSTF, 32'h0);
        chk(rd, 32'h1 << b);
        wb(1'h1, PMRC_OFF_RSTF, 32'hFFFFFFFF);
    endtask

    task automatic run_case(input logic [1:0] am, input logic [1:0] mm, input logic [8:0] c,
        input logic wk, input pmrc_sys_t ex);
        wb(1'h1, PMRC_OFF_CTRL, {23'h0, c});
        wakeup_pending <= wk;
        app_mode <= am;
        mcu_mode <= mm;
        repeat (6) @(posedge clock);
        chk(sys_mode, ex);
        chk(bus_clk_stall, ex != PMRC_S_RUN);
        chk(core_domain_power, ex != PMRC_S_STBY);
        if (!wk) chk(app_state, am);
        if (!wk) chk(mcu_state, mm);
        if (ex == PMRC_S_STOP) begin
            chk(low_power_regulator, c[PMRC_CTRL_LP] | c[PMRC_CTRL_LPLV]);
            chk(osc_enable, !c[PMRC_CTRL_OSC_OFF]);
        end
        app_mode <= 2'h0;
        mcu_mode <= 2'h0;
        wakeup_pending <= 1'h1;
        repeat (2) @(posedge clock);
        wakeup_pending <= 1'h0;
        wait_rst;
        chk(sys_mode, PMRC_S_RUN);
        wb(1'h0, PMRC_OFF_RSTF, 32'h0);
        chk(rd[PMRC_RF_STBY], ex == PMRC_S_STBY);
        wb(1'h1, PMRC_OFF_RSTF, 32'hFFFFFFFF);
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'h1;
        wait_rst;
        chk(sys_clk_src, PMRC_SRC_FAST_INT);
        chk(sys_mode, PMRC_S_RUN);
        wb(1'h0, PMRC_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        wb(1'h0, PMRC_OFF_GATE, 32'h0);
        chk(rd, PMRC_GATE_RESET);
        wb(1'h0, 8'h40, 32'h0);
        chk(er, 1'h1);
        wb(1'h1, PMRC_OFF_RSTF, 32'hFFFFFFFF);
        wb(1'h0, PMRC_OFF_RSTF, 32'h0);
        chk(rd, 32'h0);
        run_case(2'h1, 2'h2, 9'h000, 1'h0, PMRC_S_RUN);
        run_case(2'h2, 2'h1, 9'h000, 1'h0, PMRC_S_RUN);
        run_case(2'h2, 2'h2, 9'h000, 1'h1, PMRC_S_RUN);
        run_case(2'h2, 2'h2, 9'h020, 1'h0, PMRC_S_STOP);
        run_case(2'h2, 2'h2, 9'h008, 1'h0, PMRC_S_STOP);
        run_case(2'h2, 2'h2, 9'h010, 1'h0, PMRC_S_STOP);
        run_case(2'h2, 2'h2, 9'h005, 1'h0, PMRC_S_STOP);
        run_case(2'h2, 2'h2, 9'h007, 1'h0, PMRC_S_STBY);
        run_case(2'h3, 2'h2, 9'h004, 1'h0, PMRC_S_STBY);
        wb(1'h1, PMRC_OFF_GATE, 32'h0000A5A5);
        wb(1'h1, PMRC_OFF_DIV, 32'h00000021);
        chk(periph_clk_en, 32'h0000A5A5);
        wb(1'h0, PMRC_OFF_DIV, 32'h0);
        chk(rd, 32'h00000021);
        repeat (12) begin
            @(posedge clock);
            cpu_pulses += cpu_clk_en;
            bus_pulses += bus_clk_en;
        end
        chk(cpu_pulses, 6);
        chk(bus_pulses, 4);
        for (int i = 0; i < 5; i++) begin
            wb(1'h1, PMRC_OFF_CLKSEL, i);
            repeat (2) @(posedge clock);
            chk(sys_clk_src, i);
        end
        wb(1'h1, PMRC_OFF_CLKSEL, 32'h00000F53);
        repeat (2) @(posedge clock);
        chk(kernel_clk_src, PMRC_SRC_PLL);
        chk(pll_enable, 4'hF);
        wb(1'h1, PMRC_OFF_CTRL, 32'h00000080);
        flag_chk(PMRC_RF_SW_APP);
        chk(sys_clk_src, PMRC_SRC_FAST_INT);
        chk(kernel_clk_src, PMRC_SRC_PLL);
        chk(periph_clk_en, PMRC_GATE_RESET);
        wb(1'h1, PMRC_OFF_CTRL, 32'h00000100);
        flag_chk(PMRC_RF_SW_MCU);
        for (int i = 0; i < 5; i++) begin
            rst_src <= pmrc_rst_src_t'(srcv[i]);
            repeat (2) @(posedge clock);
            chk(sys_reset, 1'h1);
            chk(app_reset, i < 4);
            rst_src <= '0;
            flag_chk(flg[i]);
        end
        wb(1'h1, PMRC_OFF_CTRL, 32'h00000040);
        external_fast_osc_fail <= 1'h1;
        repeat (2) @(posedge clock);
        chk(app_reset, 1'h1);
        external_fast_osc_fail <= 1'h0;
        flag_chk(PMRC_RF_CSS);
        brownout_level_sel <= 2'h1;
        vdd_below_level <= 3'h1;
        repeat (3) @(posedge clock);
        chk(sys_reset, 1'h0);
        vdd_below_level <= 3'h2;
        repeat (2) @(posedge clock);
        chk(app_reset, 1'h1);
        vdd_below_level <= 3'h0;
        flag_chk(PMRC_RF_BOR);
        rst_src.pad <= 1'h1;
        @(posedge clock);
        rst_src.pad <= 1'h0;
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        wait_rst;
        chk(kernel_clk_src, PMRC_SRC_FAST_INT);
        chk(pll_enable, 4'h0);
        wb(1'h0, PMRC_OFF_RSTF, 32'h0);
        chk(rd, 32'h0);
        final_report;
    end

    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        final_report;
    end
endmodule
